/* File: hdl/core_regs.vh */
// constants for the 8-bit core datapath
`ifndef CORE_REGS_VH
`define CORE_REGS_VH
// -----------------------------------------------------------------
// widths and sizes
// -----------------------------------------------------------------
`define INSN_W        14
`define DATA_W        8
`define PC_W          11
`define PROG_WORDS    2048
`define FILE_ADDR_W   7
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CYCLE_NS      20
`define INSN_CYCLE_NS 200
`define INSN_CYCLES   ((`INSN_CYCLE_NS + `CYCLE_NS - 1) / `CYCLE_NS)
// -----------------------------------------------------------------
// special register addresses in file space
// -----------------------------------------------------------------
`define ADDR_INDF     7'h00
`define ADDR_PCL      7'h02
`define ADDR_STATUS   7'h03
`define ADDR_FSR      7'h04
`define ADDR_PCLATH   7'h0a
// -----------------------------------------------------------------
// status bit positions and reset values
// -----------------------------------------------------------------
`define ST_CARRY      0
`define ST_NIBBLE     1
`define ST_ZERO       2
`define STATUS_RST    8'h18
// -----------------------------------------------------------------
// alu operation codes
// -----------------------------------------------------------------
`define OP_PASSB      4'h0
`define OP_ADD        4'h1
`define OP_SUB        4'h2
`define OP_AND        4'h3
`define OP_OR         4'h4
`define OP_XOR        4'h5
`define OP_COM        4'h6
`define OP_INC        4'h7
`define OP_DEC        4'h8
`define OP_RLF        4'h9
`define OP_RRF        4'ha
`define OP_SWAP       4'hb
`define OP_CLR        4'hc
`define OP_BCF        4'hd
`define OP_BSF        4'he
`endif

/* File: hdl/core_alu.v */
// 8-bit alu with carry, nibble carry and zero outputs
`timescale 1ns/10ps
module core_alu #(
  parameter W = 8
) (
  input  wire [3:0]   op,       // operation code
  input  wire [W-1:0] a,        // working accumulator
  input  wire [W-1:0] b,        // file or literal operand
  input  wire [2:0]   bit_sel,  // bit index for bit ops
  input  wire         carry_in, // current carry flag
  output reg  [W-1:0] result,   // result byte
  output reg          carry,    // carry / not-borrow
  output reg          nibble,   // nibble carry / not-borrow
  output wire         zero      // result is zero
);
`include "core_regs.vh"
  reg [W:0] sum;
  reg [4:0] low;
  // -----------------------------------------------------------------
  // operation select
  // -----------------------------------------------------------------
  always @* begin
    sum    = {(W+1){1'b0}};
    low    = 5'h00;
    result = b;
    carry  = carry_in;
    nibble = 1'b0;
    case (op)
      `OP_ADD: begin
        sum    = {1'b0, b} + {1'b0, a};
        low    = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        result = sum[W-1:0];
        carry  = sum[W];
        nibble = low[4];
      end
      `OP_SUB: begin
        sum    = {1'b0, b} + {1'b0, ~a} + {{W{1'b0}}, 1'b1};
        low    = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        result = sum[W-1:0];
        carry  = sum[W];
        nibble = low[4];
      end
      `OP_AND:  result = a & b;
      `OP_OR:   result = a | b;
      `OP_XOR:  result = a ^ b;
      `OP_COM:  result = ~b;
      `OP_INC:  result = b + {{(W-1){1'b0}}, 1'b1};
      `OP_DEC:  result = b - {{(W-1){1'b0}}, 1'b1};
      `OP_RLF: begin
        result = {b[W-2:0], carry_in};
        carry  = b[W-1];
      end
      `OP_RRF: begin
        result = {carry_in, b[W-1:1]};
        carry  = b[0];
      end
      `OP_SWAP: result = {b[3:0], b[W-1:4]};
      `OP_CLR:  result = {W{1'b0}};
      `OP_BCF:  result = b & ~({{(W-1){1'b0}}, 1'b1} << bit_sel);
      `OP_BSF:  result = b | ({{(W-1){1'b0}}, 1'b1} << bit_sel);
      default:  result = b;
    endcase
  end
  assign zero = (result == {W{1'b0}});
endmodule // core_alu

/* File: hdl/core_datapath.v */
// two-stage execution core of the 8-bit microcontroller
//
// Function
// - fetch one 14-bit word per cycle on separate program bus
// - fetch of next instruction overlaps execution of current one
// - instructions that leave program flow alone complete in one instruction cycle
// - program flow changes take two instruction cycles
// - program counter spans 512, 1K or 2K internal words
// - special registers including pc mapped in data space, direct and indirect
// - 8-bit alu adds, subtracts, shifts and does logic
// - arithmetic is two's complement
// - two-operand ops use accumulator with file register or literal
// - single-operand ops act on accumulator or file register
// - accumulator is 8 bits and has no data address
// - alu updates carry, nibble carry and zero per instruction, except when STATUS is the file destination
// - in subtraction carry and nibble carry mean no borrow
`timescale 1ns/10ps
module core_datapath #(
  parameter PC_W  = 11,   // 9, 10 or 11 for 512, 1K, 2K words
  parameter RAM_N = 128   // general file bytes
) (
  input  wire        CLK_SYS,   // system clock, 50 MHz
  input  wire        RST,       // synchronous reset, active high
  output reg  [10:0] PROG_ADDR, // program memory word address
  input  wire [13:0] PROG_DATA, // instruction word, valid one cycle after address
  output reg         INSN_STEP, // pulse: instruction completed
  output reg  [7:0]  ACC,       // working accumulator
  output reg  [7:0]  STATUS     // status register
);
`include "core_regs.vh"
  localparam ST_FILL = 1'b0;
  localparam ST_EXEC = 1'b1;
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  reg          state;
  reg  [3:0]   phase;            // sub-cycle counter within instruction cycle
  reg  [13:0]  insn;             // instruction being executed
  reg  [10:0]  pc;
  reg  [7:0]   pclath;
  reg  [7:0]   fsr;
  reg  [7:0]   ram [0:RAM_N-1];
  reg  [10:0]  stack [0:7];
  reg  [2:0]   sp;
  wire         last = (phase == `INSN_CYCLES - 1);
  wire [10:0]  pc_mask = (11'h001 << PC_W) - 11'h001;
  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire [1:0]   grp   = insn[13:12];
  wire [3:0]   sub   = insn[11:8];
  wire         dest  = insn[7];
  wire [6:0]   faddr = insn[6:0];
  wire [7:0]   lit   = insn[7:0];
  wire [6:0]   eaddr = (faddr == `ADDR_INDF) ? fsr[6:0] : faddr;
  function [7:0] file_read;
    input [6:0] adr;
    begin
      case (adr)
        `ADDR_INDF:   file_read = 8'h00;
        `ADDR_PCL:    file_read = pc[7:0];
        `ADDR_STATUS: file_read = STATUS;
        `ADDR_FSR:    file_read = fsr;
        `ADDR_PCLATH: file_read = pclath;
        default:      file_read = (adr < RAM_N) ? ram[adr] : 8'h00;
      endcase
    end
  endfunction
  wire [7:0]   fval = file_read(eaddr);
  // -----------------------------------------------------------------
  // operation decode to alu code and flag mask {c,dc,z}
  // -----------------------------------------------------------------
  reg [3:0] op;
  reg [7:0] opb;
  reg [2:0] fmask;
  reg       wr_file;
  reg       wr_acc;
  reg       branch;
  reg       skip_test;
  reg       skip_on_set;
  always @* begin
    op = `OP_PASSB; opb = fval; fmask = 3'b000;
    wr_file = 1'b0; wr_acc = 1'b0; branch = 1'b0;
    skip_test = 1'b0; skip_on_set = 1'b0;
    case (grp)
      // file operand, result to acc or file; sub 0 moves acc to file
      2'b00: begin
        wr_file = dest;
        wr_acc  = ~dest;
        case (sub)
          4'h0: begin wr_file = dest; wr_acc = 1'b0; op = dest ? `OP_PASSB : `OP_PASSB; opb = ACC; end
          4'h1: begin op = `OP_CLR; fmask = 3'b001; end
          4'h2: begin op = `OP_SUB; fmask = 3'b111; end
          4'h3: begin op = `OP_DEC; fmask = 3'b001; end
          4'h4: begin op = `OP_OR;  fmask = 3'b001; end
          4'h5: begin op = `OP_AND; fmask = 3'b001; end
          4'h6: begin op = `OP_XOR; fmask = 3'b001; end
          4'h7: begin op = `OP_ADD; fmask = 3'b111; end
          4'h8: begin op = `OP_PASSB; fmask = 3'b001; end
          4'h9: begin op = `OP_COM; fmask = 3'b001; end
          4'ha: begin op = `OP_INC; fmask = 3'b001; end
          4'hb: begin op = `OP_DEC; skip_test = 1'b1; end
          4'hc: begin op = `OP_RRF; fmask = 3'b100; end
          4'hd: begin op = `OP_RLF; fmask = 3'b100; end
          4'he: op = `OP_SWAP;
          default: begin op = `OP_INC; skip_test = 1'b1; end
        endcase
      end
      // bit set, clear and test
      2'b01: begin
        case (sub[3:2])
          2'b00: begin op = `OP_BCF; wr_file = 1'b1; end
          2'b01: begin op = `OP_BSF; wr_file = 1'b1; end
          2'b10: begin skip_test = 1'b1; skip_on_set = 1'b0; end
          default: begin skip_test = 1'b1; skip_on_set = 1'b1; end
        endcase
      end
      2'b10: branch = 1'b1;
      default: begin
        opb = lit; wr_acc = 1'b1;
        case (sub[3:1])
          3'b100:  begin op = `OP_OR;  fmask = 3'b001; end
          3'b101:  begin op = `OP_AND; fmask = 3'b001; end
          3'b110:  begin op = sub[0] ? `OP_ADD : `OP_SUB; fmask = 3'b111; end
          3'b111:  begin op = `OP_XOR; fmask = 3'b001; end
          default: op = `OP_PASSB;
        endcase
      end
    endcase
  end
  // -----------------------------------------------------------------
  // alu
  // -----------------------------------------------------------------
  wire [7:0] res;
  wire       c_out;
  wire       dc_out;
  wire       z_out;
  wire [2:0] bsel = {sub[1:0], dest};
  core_alu #(.W(8)) alu (
    .op       (op),
    .a        (ACC),
    .b        (opb),
    .bit_sel  (bsel),
    .carry_in (STATUS[`ST_CARRY]),
    .result   (res),
    .carry    (c_out),
    .nibble   (dc_out),
    .zero     (z_out)
  );
  wire bit_val = fval[bsel];
  wire skip    = skip_test & ((grp == 2'b00) ? z_out : (bit_val == skip_on_set));
  wire ret_op  = (insn == 14'h0008) | (grp == 2'b11 && sub[3:2] == 2'b01);
  wire pcl_wr  = wr_file & (eaddr == `ADDR_PCL);
  wire flow    = branch | ret_op | skip | pcl_wr;
  // -----------------------------------------------------------------
  // pipeline: fetch address advances while insn executes
  // -----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      state <= ST_FILL; phase <= 4'h0; insn <= 14'h0000;
      pc <= 11'h000; PROG_ADDR <= 11'h000; INSN_STEP <= 1'b0;
      ACC <= 8'h00; STATUS <= `STATUS_RST; fsr <= 8'h00; pclath <= 8'h00; sp <= 3'h0;
    end else begin
      INSN_STEP <= 1'b0;
      phase <= last ? 4'h0 : phase + 4'h1;
      if (last) begin
        case (state)
          ST_FILL: begin
            insn <= PROG_DATA; state <= ST_EXEC;
            pc <= (pc + 11'h001) & pc_mask; PROG_ADDR <= (pc + 11'h001) & pc_mask;
          end
          ST_EXEC: begin
            INSN_STEP <= 1'b1;
            if (wr_acc) ACC <= (ret_op) ? lit : res;
            if (fmask[0]) STATUS[`ST_ZERO] <= z_out;
            if (fmask[1]) STATUS[`ST_NIBBLE] <= dc_out;
            if (fmask[2]) STATUS[`ST_CARRY] <= c_out;
            if (wr_file) begin
              case (eaddr)
                `ADDR_STATUS: STATUS <= {res[7:3], STATUS[2:0]};
                `ADDR_FSR:    fsr <= res;
                `ADDR_PCLATH: pclath <= res;
                `ADDR_PCL:    ;
                default:      if (eaddr < RAM_N) ram[eaddr] <= res;
              endcase
            end
            if (flow) begin
              state <= ST_FILL;
              if (branch) begin
                if (~sub[3]) begin stack[sp] <= pc; sp <= sp + 3'h1; end
                // target field already spans the full 2K space, so the page bits fall away
                PROG_ADDR <= insn[10:0] & pc_mask;
                pc        <= insn[10:0] & pc_mask;
              end else if (ret_op) begin
                PROG_ADDR <= stack[sp - 3'h1]; pc <= stack[sp - 3'h1]; sp <= sp - 3'h1;
              end else if (pcl_wr) begin
                PROG_ADDR <= {pclath[2:0], res} & pc_mask; pc <= {pclath[2:0], res} & pc_mask;
              end else begin
                PROG_ADDR <= (pc + 11'h001) & pc_mask; pc <= (pc + 11'h001) & pc_mask;
              end
            end else begin
              insn <= PROG_DATA;
              PROG_ADDR <= (pc + 11'h001) & pc_mask; pc <= (pc + 11'h001) & pc_mask;
            end
          end
          default: state <= ST_FILL;
        endcase
      end
    end
  end
endmodule // core_datapath

/* File: verification/prog_rom.sv */
// program memory model seen by the core's fetch port
`timescale 1ns/10ps
module prog_rom #(
  parameter int AW = 11 // word address width
) (
  input  wire logic          clk,  // system clock
  input  wire logic [AW-1:0] addr, // word address from the core
  output logic      [13:0]   data  // instruction word, one clock late
);
  logic [13:0] mem [2**AW];

  // unused words read as a no-op
  initial begin
    for (int i = 0; i < 2**AW; i++) mem[i] = 14'h0000;
  end

  // registered read: no word is ready before a clock has passed
  always @(posedge clk) begin
    data <= mem[addr];
  end
endmodule // prog_rom

/* File: verification/core_datapath_asserts.sv */
// port checker for the core datapath
`timescale 1ns/10ps
module core_datapath_asserts (
  input wire logic        CLK_SYS,   // system clock
  input wire logic        RST,       // sync reset
  input wire logic [10:0] PROG_ADDR, // fetch address
  input wire logic [13:0] PROG_DATA, // fetched word
  input wire logic        INSN_STEP, // completion pulse
  input wire logic [7:0]  ACC,       // accumulator
  input wire logic [7:0]  STATUS     // status byte
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // word under execution, latched as the fetch address moves on
  logic [13:0] cur;
  always_ff @(posedge CLK_SYS) begin
    if (RST) cur <= 14'h0000;
    else if ($changed(PROG_ADDR)) cur <= PROG_DATA;
  end

  property p_step_one; INSN_STEP |=> !INSN_STEP [*8]; endproperty
  property p_step_gap; INSN_STEP |-> (##10 INSN_STEP) or (##20 INSN_STEP); endproperty
  property p_addr_hold; $changed(PROG_ADDR) |=> $stable(PROG_ADDR) [*8]; endproperty
  property p_addr_step; INSN_STEP |-> $changed(PROG_ADDR); endproperty
  property p_acc_step; !$past(RST) && $changed({ACC, STATUS}) |-> INSN_STEP; endproperty
  property p_add;
    INSN_STEP && cur[13:8] == 6'h3d |-> {STATUS[0], ACC} == {1'b0, $past(ACC)} + {1'b0, cur[7:0]}
      && STATUS[1] == (({1'b0, $past(ACC[3:0])} + {1'b0, cur[3:0]}) > 5'h0f) && STATUS[2] == (ACC == 8'h00);
  endproperty
  property p_sub;
    INSN_STEP && cur[13:8] == 6'h3c |-> {~STATUS[0], ACC} == {1'b0, cur[7:0]} - {1'b0, $past(ACC)}
      && STATUS[1] == (cur[3:0] >= $past(ACC[3:0]));
  endproperty
  property p_logic;
    INSN_STEP && cur[13:8] inside {6'h38, 6'h39, 6'h3a, 6'h3b, 6'h3e, 6'h3f} |->
      STATUS[1:0] == $past(STATUS[1:0]) && STATUS[2] == (ACC == 8'h00);
  endproperty
  property p_load; INSN_STEP && cur[13:10] == 4'hc |-> ACC == cur[7:0] && STATUS == $past(STATUS); endproperty

  a_step_one: assert property (p_step_one) else $error("step pulse too long");
  a_step_gap: assert property (p_step_gap) else $error("step spacing wrong");
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved early");
  a_addr_step: assert property (p_addr_step) else $error("no fetch with step");
  a_acc_step: assert property (p_acc_step) else $error("result outside step");
  a_add: assert property (p_add) else $error("add result or flags wrong");
  a_sub: assert property (p_sub) else $error("subtract result or borrow wrong");
  a_logic: assert property (p_logic) else $error("logic op flags wrong");
  a_load: assert property (p_load) else $error("literal load wrong");

  c_branch: cover property (INSN_STEP ##20 INSN_STEP);
  c_carry: cover property (INSN_STEP && cur[13:8] == 6'h3d && STATUS[0]);
  c_borrow: cover property (INSN_STEP && cur[13:8] == 6'h3c && !STATUS[0]);
endmodule // core_datapath_asserts

bind core_datapath core_datapath_asserts i_core_datapath_asserts (.CLK_SYS(CLK_SYS), .RST(RST),
  .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .INSN_STEP(INSN_STEP), .ACC(ACC), .STATUS(STATUS));

/* File: verification/core_datapath_tb.sv */
// self-checking bench for the core datapath
`timescale 1ns/10ps
module core_datapath_tb;
  typedef struct { logic [7:0] acc; logic [7:0] st; logic [10:0] addr; int gap; } row_t;
  logic        CLK_SYS, RST, INSN_STEP;
  logic [10:0] PROG_ADDR;
  logic [13:0] PROG_DATA;
  logic [7:0]  ACC, STATUS;
  int          error_cnt, compares, n;
  // loads, adds, subtracts, logic ops, a jump over two words, a jump to itself
  // literal group codes: 3c sub, 3d add, 38 or, 3a and, 3e xor, 30 load
  logic [13:0] prog [14] = '{14'h300f, 14'h3d01, 14'h3df0, 14'h3005, 14'h3c03, 14'h3cff, 14'h3a00,
                             14'h3880, 14'h3e80, 14'h280c, 14'h30aa, 14'h30bb, 14'h305a, 14'h280d};
  // per step: accumulator, status, next fetch address, clocks since last step
  row_t rows [12] = '{'{8'h0f, 8'h18, 11'd2, 20}, '{8'h10, 8'h1a, 11'd3, 10}, '{8'h00, 8'h1d, 11'd4, 10},
                      '{8'h05, 8'h1d, 11'd5, 10}, '{8'hfe, 8'h18, 11'd6, 10}, '{8'h01, 8'h1b, 11'd7, 10},
                      '{8'h00, 8'h1f, 11'd8, 10}, '{8'h80, 8'h1b, 11'd9, 10}, '{8'h00, 8'h1f, 11'd10, 10},
                      '{8'h00, 8'h1f, 11'd12, 10}, '{8'h5a, 8'h1f, 11'd14, 20}, '{8'h5a, 8'h1f, 11'd13, 10}};

  core_datapath #(.PC_W(11), .RAM_N(128)) i_core_datapath (.CLK_SYS(CLK_SYS), .RST(RST), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .INSN_STEP(INSN_STEP), .ACC(ACC), .STATUS(STATUS));
  prog_rom #(.AW(11)) i_prog_rom (.clk(CLK_SYS), .addr(PROG_ADDR), .data(PROG_DATA));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait, so a core that never completes cannot hang us
  task automatic wait_step(output int cnt);
    cnt = 0;
    do begin
      @(negedge CLK_SYS);
      cnt++;
    end while (INSN_STEP !== 1'b1 && cnt < 100);
  endtask

  task automatic final_report;
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  // watchdog: the run needs some 167 cycles, this allows 3000, nearly eighteen times more
  initial begin
    #60000;
    error_cnt++;
    final_report;
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    RST = 1'b1;
    error_cnt = 0;
    compares = 0;
    #1;
    for (int i = 0; i < 14; i++) i_prog_rom.mem[i] = prog[i];
    repeat (6) @(negedge CLK_SYS);
    RST = 1'b0;
    foreach (rows[i]) begin
      wait_step(n);
      check(n, rows[i].gap);
      check(ACC, rows[i].acc);
      check(STATUS, rows[i].st);
      check(PROG_ADDR, rows[i].addr);
    end
    RST = 1'b1;
    @(negedge CLK_SYS);
    RST = 1'b0;
    check({ACC, STATUS, INSN_STEP}, {8'h00, 8'h18, 1'b0});
    check(PROG_ADDR, 11'd0);
    wait_step(n);
    check(n, 20);
    check(ACC, 8'h0f);
    final_report;
  end
endmodule // core_datapath_tb
